// ===== rtl/cbspd_core.v
// Bus-state output control and power-down sequencing of an 8-bit multiplexed-bus CPU
`timescale 1ns/1ps
`include "cbspd_regs.vh"

module cbspd_core (
   input  wire        sys_clk,
   input  wire        rstn,
   input  wire        req_valid,
   input  wire [2:0]  req_type,
   input  wire [15:0] req_addr,
   input  wire [7:0]  req_wdata,
   input  wire        req_bus_idle,
   input  wire        req_long,
   input  wire        halt_exec,
   input  wire        int_enable,
   input  wire [2:0]  restart_mask,
   input  wire        ready_pin,
   input  wire        hold_pin,
   input  wire        nmi_pin,
   input  wire        restart_int_edge,
   input  wire        restart_int_level_high,
   input  wire        restart_int_level_low,
   input  wire        general_interrupt_request,
   input  wire [7:0]  muxed_low_address_data_in,
   output reg         req_ready_q,
   output reg         cycle_done_q,
   output reg  [7:0]  read_data_q,
   output reg         wake_int_q,
   output reg  [2:0]  wake_src_q,
   output reg         power_down_q,
   output reg         hold_ack_q,
   output reg         status_bit_zero_q,
   output reg         status_bit_one_q,
   output reg         io_mem_sel_q,
   output reg         io_mem_sel_oe_q,
   output reg  [7:0]  upper_address_byte_q,
   output reg         upper_address_byte_oe_q,
   output reg  [7:0]  muxed_low_address_data_q,
   output reg         muxed_low_address_data_oe_q,
   output reg         read_n_q,
   output reg         write_n_q,
   output reg         strobe_oe_q,
   output reg         interrupt_acknowledge_n_q,
   output reg         ale_q
);

   // T-state divider: one enable pulse per T state
   reg [`CBSPD_DIV_W-1:0] div_q;
   reg                    tick_q;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         div_q  <= 4'h0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == (`CBSPD_T_DIV - 1));
         if (div_q == (`CBSPD_T_DIV - 1))
            div_q <= 4'h0;
         else
            div_q <= div_q + 4'h1;
      end
   end

   // Pin synchronisers; only the second stage is read by logic
   reg [6:0] pin_s1_q;
   reg [6:0] pin_s2_q;
   reg       edge_prev_q;
   reg       edge_latch_q;
   reg       nmi_prev_q;
   reg       nmi_armed_q;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_q <= 7'h00;
         pin_s2_q <= 7'h00;
      end else begin
         pin_s1_q <= {ready_pin, hold_pin, nmi_pin, restart_int_edge, restart_int_level_high,
                      restart_int_level_low, general_interrupt_request};
         pin_s2_q <= pin_s1_q;
      end
   end

   wire ready_s = pin_s2_q[6];
   wire hold_s  = pin_s2_q[5];
   wire nmi_s   = pin_s2_q[4];
   wire edge_s  = pin_s2_q[3];
   wire lvlh_s  = pin_s2_q[2];
   wire lvll_s  = pin_s2_q[1];
   wire gen_s   = pin_s2_q[0];

   // Machine state and captured cycle
   reg [`CBSPD_ST_W-1:0]  st_q;
   reg [`CBSPD_ST_W-1:0]  st_d;
   reg [`CBSPD_CYC_W-1:0] cyc_q;
   reg [15:0]             addr_q;
   reg [7:0]              wdata_q;
   reg                    idle_cyc_q;
   reg                    long_q;

   // Accepted interrupt while halted, fixed priority nmi, edge, level high, level low, general
   wire nmi_hit  = nmi_s & nmi_armed_q;
   wire edge_hit = edge_latch_q & ~restart_mask[2] & int_enable;
   wire lvlh_hit = lvlh_s & ~restart_mask[1] & int_enable;
   wire lvll_hit = lvll_s & ~restart_mask[0] & int_enable;
   wire gen_hit  = gen_s & int_enable;
   wire int_hit  = nmi_hit | edge_hit | lvlh_hit | lvll_hit | gen_hit;
   wire take_wake = tick_q & (st_q == `CBSPD_ST_HALT) & int_hit;

   // Edge request stays latched until any wake not taken by the non-maskable input; a new edge wins over the clear
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         edge_prev_q  <= 1'b0;
         edge_latch_q <= 1'b0;
         nmi_prev_q   <= 1'b0;
         nmi_armed_q  <= 1'b0;
      end else begin
         edge_prev_q <= edge_s;
         nmi_prev_q  <= nmi_s;
         if (edge_s & ~edge_prev_q)
            edge_latch_q <= 1'b1;
         else if (take_wake & ~nmi_hit)
            edge_latch_q <= 1'b0;
         // Non-maskable input must fall and rise again before it counts twice
         if (nmi_s & ~nmi_prev_q)
            nmi_armed_q <= 1'b1;
         else if ((take_wake & nmi_hit) | ~nmi_s)
            nmi_armed_q <= 1'b0;
      end
   end

   function [2:0] stat_code;
      input [2:0] t;
      input       bi;
      begin
         if (bi)
            stat_code = `CBSPD_STAT_BI;
         else begin
            case (t)
               `CBSPD_CYC_OF:  stat_code = `CBSPD_STAT_OF;
               `CBSPD_CYC_MR:  stat_code = `CBSPD_STAT_MR;
               `CBSPD_CYC_MW:  stat_code = `CBSPD_STAT_MW;
               `CBSPD_CYC_IOR: stat_code = `CBSPD_STAT_IOR;
               `CBSPD_CYC_IOW: stat_code = `CBSPD_STAT_IOW;
               `CBSPD_CYC_INA: stat_code = `CBSPD_STAT_INA;
               default:        stat_code = `CBSPD_STAT_BI;
            endcase
         end
      end
   endfunction

   wire is_write = (cyc_q == `CBSPD_CYC_MW) | (cyc_q == `CBSPD_CYC_IOW);
   wire is_ina   = (cyc_q == `CBSPD_CYC_INA);
   wire is_of    = (cyc_q == `CBSPD_CYC_OF);
   wire has_t4   = is_of | is_ina;

   // Next state, evaluated once per T state; new work starts only from idle
   always @* begin
      st_d = st_q;
      case (st_q)
         `CBSPD_ST_IDLE: begin
            if (halt_exec)
               st_d = `CBSPD_ST_HALT;
            else if (hold_s)
               st_d = `CBSPD_ST_HOLD;
            else if (req_valid & req_ready_q)
               st_d = `CBSPD_ST_T1;
         end
         `CBSPD_ST_T1: st_d = `CBSPD_ST_T2;
         `CBSPD_ST_T2: st_d = (ready_s | idle_cyc_q) ? `CBSPD_ST_T3 : `CBSPD_ST_TW;
         `CBSPD_ST_TW: st_d = ready_s ? `CBSPD_ST_T3 : `CBSPD_ST_TW;
         `CBSPD_ST_T3: st_d = has_t4 ? `CBSPD_ST_T4 : `CBSPD_ST_IDLE;
         `CBSPD_ST_T4: st_d = long_q ? `CBSPD_ST_T5 : `CBSPD_ST_IDLE;
         `CBSPD_ST_T5: st_d = `CBSPD_ST_T6;
         `CBSPD_ST_T6: st_d = `CBSPD_ST_IDLE;
         `CBSPD_ST_HALT: st_d = int_hit ? `CBSPD_ST_IDLE : `CBSPD_ST_HALT;
         `CBSPD_ST_HOLD: st_d = hold_s ? `CBSPD_ST_HOLD : `CBSPD_ST_IDLE;
         default: st_d = `CBSPD_ST_IDLE;
      endcase
   end

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_q       <= `CBSPD_ST_IDLE;
         cyc_q      <= `CBSPD_CYC_OF;
         addr_q     <= 16'h0000;
         wdata_q    <= 8'h00;
         idle_cyc_q <= 1'b0;
         long_q     <= 1'b0;
      end else if (tick_q) begin
         st_q <= st_d;
         if ((st_q == `CBSPD_ST_IDLE) && (st_d == `CBSPD_ST_T1)) begin
            cyc_q      <= req_type;
            addr_q     <= req_addr;
            wdata_q    <= req_wdata;
            idle_cyc_q <= req_bus_idle;
            long_q     <= req_long & (req_type == `CBSPD_CYC_OF);
         end
      end
   end

   // Core-side handshake and status
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         req_ready_q  <= 1'b0;
         cycle_done_q <= 1'b0;
         read_data_q  <= 8'h00;
         wake_int_q   <= 1'b0;
         wake_src_q   <= 3'h0;
         power_down_q <= 1'b0;
         hold_ack_q   <= 1'b0;
      end else begin
         cycle_done_q <= 1'b0;
         wake_int_q   <= 1'b0;
         if (tick_q) begin
            req_ready_q  <= (st_d == `CBSPD_ST_IDLE) & ~halt_exec & ~hold_s;
            power_down_q <= (st_d == `CBSPD_ST_HALT) | (st_d == `CBSPD_ST_HOLD);
            // Halt grants hold status to a requester; release of hold keeps the halt
            hold_ack_q   <= (st_d == `CBSPD_ST_HOLD) | ((st_d == `CBSPD_ST_HALT) & hold_s);
            if (st_d == `CBSPD_ST_IDLE && st_q != `CBSPD_ST_IDLE && st_q != `CBSPD_ST_HALT &&
                st_q != `CBSPD_ST_HOLD)
               cycle_done_q <= 1'b1;
            if ((st_q == `CBSPD_ST_T3) && !is_write && !idle_cyc_q)
               read_data_q <= muxed_low_address_data_in;
            if (take_wake) begin
               wake_int_q <= 1'b1;
               wake_src_q <= nmi_hit ? 3'h0 : edge_hit ? 3'h1 : lvlh_hit ? 3'h2 : lvll_hit ? 3'h3 : 3'h4;
            end
         end
      end
   end

   // Pin drive per machine state; reset defaults are the reset-state levels
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         status_bit_zero_q           <= 1'b0;
         status_bit_one_q            <= 1'b0;
         io_mem_sel_q                <= 1'b0;
         io_mem_sel_oe_q             <= 1'b0;
         upper_address_byte_q        <= 8'h00;
         upper_address_byte_oe_q     <= 1'b0;
         muxed_low_address_data_q    <= 8'h00;
         muxed_low_address_data_oe_q <= 1'b0;
         read_n_q                    <= 1'b1;
         write_n_q                   <= 1'b1;
         strobe_oe_q                 <= 1'b0;
         interrupt_acknowledge_n_q   <= 1'b1;
         ale_q                       <= 1'b0;
      end else if (tick_q) begin
         read_n_q                  <= 1'b1;
         write_n_q                 <= 1'b1;
         interrupt_acknowledge_n_q <= 1'b1;
         ale_q                     <= 1'b0;
         case (st_d)
            `CBSPD_ST_T1: begin
               {io_mem_sel_q, status_bit_one_q, status_bit_zero_q} <=
                  (st_q == `CBSPD_ST_IDLE) ? stat_code(req_type, req_bus_idle) : 3'h2;
               io_mem_sel_oe_q             <= 1'b1;
               upper_address_byte_q        <= req_addr[15:8];
               upper_address_byte_oe_q     <= 1'b1;
               muxed_low_address_data_q    <= req_addr[7:0];
               muxed_low_address_data_oe_q <= ~req_bus_idle;
               strobe_oe_q                 <= 1'b1;
               ale_q                       <= ~req_bus_idle;
            end
            `CBSPD_ST_T2, `CBSPD_ST_TW, `CBSPD_ST_T3: begin
               muxed_low_address_data_q    <= wdata_q;
               muxed_low_address_data_oe_q <= is_write & ~idle_cyc_q;
               if (!idle_cyc_q) begin
                  read_n_q                  <= ~(is_of | (cyc_q == `CBSPD_CYC_MR) | (cyc_q == `CBSPD_CYC_IOR));
                  write_n_q                 <= ~is_write;
                  interrupt_acknowledge_n_q <= ~is_ina;
               end
            end
            `CBSPD_ST_T4, `CBSPD_ST_T5, `CBSPD_ST_T6: begin
               status_bit_one_q            <= 1'b1;
               io_mem_sel_q                <= is_ina;
               muxed_low_address_data_oe_q <= 1'b0;
            end
            `CBSPD_ST_HALT: begin
               status_bit_one_q            <= 1'b0;
               status_bit_zero_q           <= 1'b0;
               io_mem_sel_oe_q             <= 1'b0;
               upper_address_byte_oe_q     <= 1'b0;
               muxed_low_address_data_oe_q <= 1'b0;
               strobe_oe_q                 <= 1'b0;
            end
            `CBSPD_ST_HOLD: begin
               io_mem_sel_oe_q             <= 1'b0;
               upper_address_byte_oe_q     <= 1'b0;
               muxed_low_address_data_oe_q <= 1'b0;
               strobe_oe_q                 <= 1'b0;
            end
            default: begin
               // Idle between cycles: bus parked, data byte released
               muxed_low_address_data_oe_q <= 1'b0;
               if (st_q == `CBSPD_ST_HALT || st_q == `CBSPD_ST_HOLD) begin
                  io_mem_sel_oe_q         <= 1'b1;
                  upper_address_byte_oe_q <= 1'b1;
                  strobe_oe_q             <= 1'b1;
               end
            end
         endcase
      end
   end

endmodule // cbspd_core

// ===== rtl/cbspd_regs.vh
// Constants for the CPU bus-state and power-down block
`ifndef CBSPD_REGS_VH
`define CBSPD_REGS_VH

// Clock and T-state timing
`define CBSPD_SYS_PERIOD_NS  10
`define CBSPD_T_PERIOD_NS    40
`define CBSPD_T_DIV          (`CBSPD_T_PERIOD_NS / `CBSPD_SYS_PERIOD_NS)
`define CBSPD_DIV_W          4

// Machine state codes
`define CBSPD_ST_W           4
`define CBSPD_ST_IDLE        4'h0
`define CBSPD_ST_T1          4'h1
`define CBSPD_ST_T2          4'h2
`define CBSPD_ST_TW          4'h3
`define CBSPD_ST_T3          4'h4
`define CBSPD_ST_T4          4'h5
`define CBSPD_ST_T5          4'h6
`define CBSPD_ST_T6          4'h7
`define CBSPD_ST_HALT        4'h8
`define CBSPD_ST_HOLD        4'h9

// Machine cycle types requested by the core
`define CBSPD_CYC_W          3
`define CBSPD_CYC_OF         3'h0
`define CBSPD_CYC_MR         3'h1
`define CBSPD_CYC_MW         3'h2
`define CBSPD_CYC_IOR        3'h3
`define CBSPD_CYC_IOW        3'h4
`define CBSPD_CYC_INA        3'h5

// Status codes {io_mem_sel, status_bit_one, status_bit_zero}
`define CBSPD_STAT_OF        3'h3
`define CBSPD_STAT_MR        3'h2
`define CBSPD_STAT_MW        3'h1
`define CBSPD_STAT_IOR       3'h6
`define CBSPD_STAT_IOW       3'h5
`define CBSPD_STAT_INA       3'h7
`define CBSPD_STAT_BI        3'h2

`endif

// ===== test/cbspd_core_bench.sv
// Self-checking bench for the bus-state and power-down block
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
`define WAITF(c) begin for (w = 0; w < 400 && !(c); w++) @(posedge sys_clk) #1; if (!(c)) begin errors++; wrap_up(); end end
module cbspd_core_bench;
   reg        sys_clk = 1'b0;
   reg        rstn = 1'b0;
   reg        req_valid = 1'b0;
   reg [2:0]  req_type = 3'h0;
   reg [15:0] req_addr = 16'h0000;
   reg [7:0]  req_wdata = 8'h00;
   reg        req_bus_idle = 1'b0;
   reg        req_long = 1'b0;
   reg        halt_exec = 1'b0;
   reg        int_enable = 1'b1;
   reg [2:0]  restart_mask = 3'h0;
   reg        hold_pin = 1'b0;
   reg        slow = 1'b0;
   reg [4:0]  ints = 5'h00; // nmi, edge, level high, level low, general
   reg [9:0]  exp_q[$];
   reg [9:0]  e;
   reg [7:0]  last_rd = 8'h00;
   integer    errors = 0, n_compared = 0, w, i, seed = 32'h9322;
   wire [7:0] rdata, wseen, read_data_q, upper_address_byte_q, muxed_low_address_data_q;
   wire [2:0] wake_src_q;
   wire       ready_pin, req_ready_q, cycle_done_q, wake_int_q, power_down_q, hold_ack_q, status_bit_zero_q;
   wire       status_bit_one_q, muxed_low_address_data_oe_q, read_n_q, write_n_q, strobe_oe_q;
   wire       interrupt_acknowledge_n_q, ale_q;
   cbspd_core cbspd_core_inst (.sys_clk, .rstn, .req_valid, .req_type, .req_addr, .req_wdata, .req_bus_idle,
      .req_long, .halt_exec, .int_enable, .restart_mask, .ready_pin, .hold_pin, .nmi_pin(ints[4]),
      .restart_int_edge(ints[3]), .restart_int_level_high(ints[2]), .restart_int_level_low(ints[1]),
      .general_interrupt_request(ints[0]), .muxed_low_address_data_in(rdata), .req_ready_q, .cycle_done_q,
      .read_data_q, .wake_int_q, .wake_src_q, .power_down_q, .hold_ack_q, .status_bit_zero_q,
      .status_bit_one_q, .io_mem_sel_q(), .io_mem_sel_oe_q(), .upper_address_byte_q, .upper_address_byte_oe_q(),
      .muxed_low_address_data_q, .muxed_low_address_data_oe_q, .read_n_q, .write_n_q, .strobe_oe_q,
      .interrupt_acknowledge_n_q, .ale_q);
   cbspd_mem_model cbspd_mem_model_inst (.sys_clk, .slow, .ale_q, .upper_address_byte_q,
      .muxed_low_address_data_q, .muxed_low_address_data_oe_q, .read_n_q, .write_n_q,
      .interrupt_acknowledge_n_q, .ready_pin, .rdata, .wdata_seen(wseen));
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (rstn && (cycle_done_q || wake_int_q)) begin
      if (exp_q.size() == 0) `CHK({wake_int_q, cycle_done_q}, 2'h0)
      else begin
         e = exp_q.pop_front();
         if (e[9:8] == 2'h0) `CHK(read_data_q, e[7:0])
         else if (e[9:8] == 2'h1) `CHK(wseen, e[7:0])
         else if (e[9:8] == 2'h2) `CHK({5'h00, wake_src_q}, e[7:0])
         else `CHK(read_data_q, last_rd)
         // A bus idle cycle has no read strobe, so the last read byte must survive it
         if (e[9:8] == 2'h0) last_rd = e[7:0];
      end
   end
   task wrap_up;
      begin
         $display("Counts: %0d compared, %0d errors", n_compared, errors);
         if (errors == 0 && n_compared > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task bus(input [2:0] t, input [15:0] a, input bi, input lg);
      reg [1:0] k;
      begin
         // I/O cycles repeat the port number on both address halves
         if (t == 3'h3 || t == 3'h4) a[15:8] = a[7:0];
         k = bi ? 2'h3 : (t == 3'h2 || t == 3'h4) ? 2'h1 : 2'h0;
         `WAITF(req_ready_q === 1'b1)
         req_wdata = 8'($random(seed));
         exp_q.push_back({k, k == 2'h1 ? req_wdata : a[15:8] ^ a[7:0] ^ 8'h5a});
         req_type = t;
         req_addr = a;
         req_bus_idle = bi;
         req_long = lg;
         req_valid = 1'b1;
         `WAITF(req_ready_q === 1'b0)
         req_valid = 1'b0;
         `WAITF(cycle_done_q === 1'b1)
         @(posedge sys_clk) #1;
      end
   endtask
   task halt_now;
      begin
         halt_exec = 1'b1;
         `WAITF(power_down_q === 1'b1)
         halt_exec = 1'b0;
         repeat (8) @(posedge sys_clk) #1;
      end
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      #1 rstn = 1'b1;
      for (i = 0; i < 12; i++) begin
         slow = i[0];
         bus(3'(i % 6), 16'($random(seed)), 1'b0, i[1]);
      end
      $display("cycle types done");
      bus(3'h1, 16'($random(seed)), 1'b1, 1'b0);
      bus(3'h0, 16'($random(seed)), 1'b0, 1'b0);
      $display("bus idle done");
      for (i = 0; i < 5; i++) begin
         halt_now();
         `CHK({status_bit_one_q, status_bit_zero_q, strobe_oe_q}, 3'h0)
         hold_pin = 1'b1;
         `WAITF(hold_ack_q === 1'b1)
         hold_pin = 1'b0;
         repeat (16) @(posedge sys_clk) #1;
         `CHK(power_down_q, 1'b1)
         exp_q.push_back({2'h2, 8'(i)});
         // Masks and enable closed first: only the non-maskable input may wake
         restart_mask = 3'h7;
         int_enable = 1'b0;
         ints = 5'h10 >> i;
         repeat (12) @(posedge sys_clk) #1;
         `CHK(power_down_q, i != 0)
         restart_mask = 3'h0;
         int_enable = 1'b1;
         `WAITF(power_down_q === 1'b0)
         ints = 5'h00;
      end
      $display("halt wake done");
      hold_pin = 1'b1;
      `WAITF(hold_ack_q === 1'b1)
      ints = 5'h17;
      repeat (20) @(posedge sys_clk) #1;
      `CHK(power_down_q, 1'b1)
      ints = 5'h00;
      hold_pin = 1'b0;
      `WAITF(power_down_q === 1'b0)
      bus(3'h2, 16'($random(seed)), 1'b0, 1'b0);
      $display("hold done");
      halt_now();
      rstn = 1'b0;
      repeat (3) @(posedge sys_clk) #1;
      `CHK({power_down_q, strobe_oe_q, ale_q, interrupt_acknowledge_n_q}, 4'h1)
      rstn = 1'b1;
      `WAITF(req_ready_q === 1'b1)
      req_type = 3'h1;
      req_bus_idle = 1'b0;
      req_valid = 1'b1;
      `WAITF(read_n_q === 1'b0)
      req_valid = 1'b0;
      rstn = 1'b0;
      repeat (2) @(posedge sys_clk) #1;
      `CHK({read_n_q, strobe_oe_q, muxed_low_address_data_oe_q}, 3'h4)
      rstn = 1'b1;
      bus(3'h1, 16'($random(seed)), 1'b0, 1'b0);
      $display("reset done");
      `CHK(exp_q.size(), 0)
      wrap_up();
   end
endmodule // cbspd_core_bench

// ===== test/cbspd_core_properties.sv
// Checker for bus-state outputs and power-down behaviour
`timescale 1ns/1ps
module cbspd_core_properties (
   input wire       sys_clk,
   input wire       rstn,
   input wire [2:0] req_type,
   input wire       req_bus_idle,
   input wire       hold_pin,
   input wire       wake_int_q,
   input wire       power_down_q,
   input wire       hold_ack_q,
   input wire       status_bit_zero_q,
   input wire       status_bit_one_q,
   input wire       io_mem_sel_q,
   input wire       io_mem_sel_oe_q,
   input wire       upper_address_byte_oe_q,
   input wire       muxed_low_address_data_oe_q,
   input wire       read_n_q,
   input wire       write_n_q,
   input wire       strobe_oe_q,
   input wire       interrupt_acknowledge_n_q,
   input wire       ale_q
);
   // Cycle codes {select, status one, status zero}, indexed by request type
   localparam logic [17:0] CODES = {3'h7, 3'h5, 3'h6, 3'h1, 3'h2, 3'h3};
   wire any_oe = io_mem_sel_oe_q | upper_address_byte_oe_q | muxed_low_address_data_oe_q | strobe_oe_q;
   wire quiet  = !any_oe && !ale_q && interrupt_acknowledge_n_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // The first edge still samples flops that reset has not reached, so look from the second low edge
   reset_float_a: assert property (disable iff (1'b0) !rstn ##1 !rstn |-> quiet)
      else $error("bus driven in reset");
   ale_width_a: assert property ($rose(ale_q) |-> ale_q [*4] ##1 !ale_q) else $error("latch width wrong");
   ale_idle_a: assert property ($rose(ale_q) |-> !$past(req_bus_idle)) else $error("latch in idle cycle");
   status_code_a: assert property ($rose(ale_q) |->
      {io_mem_sel_q, status_bit_one_q, status_bit_zero_q} == CODES[3*$past(req_type) +: 3])
      else $error("status code wrong");
   ina_tail_a: assert property ($rose(interrupt_acknowledge_n_q) |->
      io_mem_sel_q && status_bit_one_q && !muxed_low_address_data_oe_q) else $error("ack tail wrong");
   rd_end_a: assert property ($rose(read_n_q) |->
      !muxed_low_address_data_oe_q && write_n_q && interrupt_acknowledge_n_q && !ale_q) else $error("T4 wrong");
   pd_float_a: assert property (power_down_q && $past(power_down_q, 8) |-> quiet) else $error("bus driven");
   hold_pd_a: assert property ($rose(hold_ack_q) |-> ##[0:4] power_down_q) else $error("hold not low power");
   hold_rel_a: assert property ($fell(hold_pin) |-> ##[1:12] !hold_ack_q) else $error("hold not released");
   wake_exit_a: assert property (wake_int_q |-> ##[0:8] !power_down_q) else $error("wake kept power down");
   cover property ($rose(power_down_q));
   cover property ($rose(hold_ack_q));
   cover property ($fell(interrupt_acknowledge_n_q));
   cover property (wake_int_q);
endmodule // cbspd_core_properties

bind cbspd_core cbspd_core_properties cbspd_core_properties_inst (.sys_clk, .rstn, .req_type, .req_bus_idle,
   .hold_pin, .wake_int_q, .power_down_q, .hold_ack_q, .status_bit_zero_q, .status_bit_one_q, .io_mem_sel_q,
   .io_mem_sel_oe_q, .upper_address_byte_oe_q, .muxed_low_address_data_oe_q, .read_n_q, .write_n_q,
   .strobe_oe_q, .interrupt_acknowledge_n_q, .ale_q);

// ===== test/cbspd_mem_model.sv
// Memory and I/O model answering the multiplexed bus
`timescale 1ns/1ps
module cbspd_mem_model (
   input  wire       sys_clk,
   input  wire       slow,
   input  wire       ale_q,
   input  wire [7:0] upper_address_byte_q,
   input  wire [7:0] muxed_low_address_data_q,
   input  wire       muxed_low_address_data_oe_q,
   input  wire       read_n_q,
   input  wire       write_n_q,
   input  wire       interrupt_acknowledge_n_q,
   output reg        ready_pin = 1'b1,
   output reg  [7:0] rdata = 8'h00,
   output reg  [7:0] wdata_seen = 8'h00
);
   reg [15:0] addr_q = 16'h0000;
   reg [3:0]  cnt_q = 4'hf;
   always @(posedge sys_clk) begin
      if (ale_q) begin
         addr_q <= {upper_address_byte_q, muxed_low_address_data_q};
         cnt_q  <= 4'h0;
      end else if (cnt_q != 4'hf) begin
         cnt_q <= cnt_q + 4'h1;
      end
      // A slow device keeps ready low long enough to force a wait state
      ready_pin <= !slow || cnt_q > 4'h5;
      // Released bus alternates each clock between the inverse of the last byte and a stale copy
      rdata <= (!read_n_q || !interrupt_acknowledge_n_q) ? addr_q[15:8] ^ addr_q[7:0] ^ 8'h5a : ~rdata;
      if (!write_n_q && muxed_low_address_data_oe_q) wdata_seen <= muxed_low_address_data_q;
   end
endmodule // cbspd_mem_model
